// >>> hw/pds_pkg.sv
package pds_pkg;
  // ==========================================================
  // Sizes
  localparam int PDS_NSRC = 4;
  localparam int PDS_NPH = 3;
  localparam int PDS_TMR_W = 24;

  // ==========================================================
  // Angles: one full turn is 2^16 counts
  localparam logic [15:0] PDS_ANG_90 = 16'h4000;
  localparam logic [15:0] PDS_ANG_180 = 16'h8000;

  // ==========================================================
  // Magnitudes: 1.000 pu is PDS_PU_ONE counts
  localparam int PDS_PU_ONE = 4096;
  localparam int PDS_IMIN_PCT = 5;
  localparam logic [15:0] PDS_IMIN = 16'((PDS_PU_ONE * PDS_IMIN_PCT + 99) / 100);
  localparam int PDS_THR_MILLI_PU = 700;
  localparam logic [15:0] PDS_THR_RST = 16'((PDS_PU_ONE * PDS_THR_MILLI_PU + 500) / 1000);
  localparam logic [15:0] PDS_ECA_RST = 16'h0000;

  // ==========================================================
  // Timing
  localparam int PDS_CLK_HZ = 10_000_000;
  localparam int PDS_MEM_VALID_S = 1;
  localparam int PDS_MEM_VALID_CYC = PDS_MEM_VALID_S * PDS_CLK_HZ;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] PDS_OFS_CTRL = 12'h000;
  localparam logic [11:0] PDS_OFS_ECA = 12'h004;
  localparam logic [11:0] PDS_OFS_THR = 12'h008;
  localparam logic [11:0] PDS_OFS_STATUS = 12'h00c;
  localparam logic [11:0] PDS_OFS_MEM_A = 12'h010;
  localparam logic [11:0] PDS_OFS_MEM_B = 12'h014;
  localparam logic [11:0] PDS_OFS_MEM_C = 12'h018;

  // Control fields
  localparam int PDS_CTRL_EN = 0;
  localparam int PDS_CTRL_ACB = 1;
  localparam int PDS_CTRL_BLK = 2;
  localparam int PDS_CTRL_SRC = 4;
  localparam logic [31:0] PDS_CTRL_RST = 32'h0000_0000;

  // Status fields, three bits each
  localparam int PDS_ST_DIR = 0;
  localparam int PDS_ST_VOK = 4;
  localparam int PDS_ST_MVAL = 8;
  localparam int PDS_ST_EXP = 12;
endpackage

// >>> hw/pds_phase_if.sv
`timescale 1ns/1ps
interface pds_phase_if;
  import pds_pkg::*;
  logic [PDS_NPH-1:0][15:0] i_mag;
  logic [PDS_NPH-1:0][15:0] i_ang;
  logic [PDS_NPH-1:0][15:0] v_mag;
  logic [PDS_NPH-1:0][15:0] v_ang;
  logic [PDS_NPH-1:0][15:0] pol_ang;
  logic [PDS_NPH-1:0] in_window;
  modport sel (output i_mag, output i_ang, output v_mag, output v_ang);
  modport core (input i_mag, input i_ang, input v_mag, input v_ang, input in_window, output pol_ang);
  modport cmp (input i_ang, input pol_ang, output in_window);
endinterface

// >>> hw/pds_src_sel.sv
`timescale 1ns/1ps
module pds_src_sel import pds_pkg::*; (
  input wire logic [1:0] src_sel,
  input wire logic acb,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] cur_mag,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] cur_ang,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] vll_mag,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] vll_ang,
  pds_phase_if.sel ph
);
  // ==========================================================
  // Quadrature line voltage per phase; line index 0=ab 1=bc 2=ca
  for (genvar p = 0; p < PDS_NPH; p++) begin : g_ph
    localparam int LN = (p + 1) % PDS_NPH;
    assign ph.i_mag[p] = cur_mag[src_sel][p];
    assign ph.i_ang[p] = cur_ang[src_sel][p];
    assign ph.v_mag[p] = vll_mag[src_sel][LN];
    // Reversed pair under the other rotation is the same phasor plus 180 degrees
    assign ph.v_ang[p] = acb ? vll_ang[src_sel][LN] + PDS_ANG_180 : vll_ang[src_sel][LN];
  end
endmodule

// >>> hw/pds_angle_cmp.sv
`timescale 1ns/1ps
module pds_angle_cmp import pds_pkg::*; (
  pds_phase_if.cmp ph
);
  // ==========================================================
  // Window test: both +90 and -90 count as inside
  for (genvar p = 0; p < PDS_NPH; p++) begin : g_ph
    logic [15:0] diff;
    assign diff = ph.i_ang[p] - ph.pol_ang[p];
    assign ph.in_window[p] = (diff[15] == diff[14]) | (diff == PDS_ANG_90);
  end
endmodule

// >>> hw/pds_top.sv
// Behaviour
// - three independent per-phase direction units
// - ABC rotation polarizes A,B,C with bc,ca,ab
// - ACB rotation polarizes A,B,C with cb,ac,ba
// - disabled or current under 5% gives 0
// - inside plus/minus 90 degrees 0, else 1
// - remember polarizing voltage from before collapse
// - memory valid one second after collapse
// - expiry option Yes blocks after memory expires
// - expiry option No releases after memory expires
// - healthy voltage resumes angle-based decisions
// - voltage threshold setting, default 0.700 pu
// - characteristic angle leads polarizing voltage
// - output 1 means inhibit the overcurrent element
// - source select feeds currents and voltages
// - blocking settles about 8 ms after reversal
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pds_top import pds_pkg::*; #(
  parameter int unsigned MEM_CYC = PDS_MEM_VALID_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] phase_current_mag,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] phase_current_ang,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] line_voltage_mag,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] line_voltage_ang,
  output logic [PDS_NPH-1:0] block_out,
  output logic [PDS_NPH-1:0] memory_expired
);

  // ==========================================================
  // State
  typedef struct packed {
    logic en;
    logic acb;
    logic blk_exp;
    logic [1:0] src;
    logic [15:0] eca;
    logic [15:0] thr;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [PDS_NPH-1:0][15:0] mem_ang;
    logic [PDS_NPH-1:0][PDS_TMR_W-1:0] tmr;
    logic [PDS_NPH-1:0] mem_valid;
    logic [PDS_NPH-1:0] expired;
    logic [PDS_NPH-1:0] v_ok;
    logic [PDS_NPH-1:0] dir;
  } pds_state_t;

  localparam logic [PDS_TMR_W-1:0] TMR_LAST = PDS_TMR_W'(MEM_CYC - 1);

  pds_state_t st_ff;
  pds_state_t nxt_st;

  pds_phase_if ph();

  logic [PDS_NPH-1:0] v_ok_c;
  logic [PDS_NPH-1:0] i_ok_c;
  logic setup_c;
  logic wr_c;
  logic mapped_c;
  logic [31:0] rd_c;

  // ==========================================================
  // Measurement selection and angle comparison
  pds_src_sel u_sel (
    .src_sel(st_ff.src),
    .acb(st_ff.acb),
    .cur_mag(phase_current_mag),
    .cur_ang(phase_current_ang),
    .vll_mag(line_voltage_mag),
    .vll_ang(line_voltage_ang),
    .ph(ph.sel)
  );

  pds_angle_cmp u_cmp (
    .ph(ph.cmp)
  );

  // ==========================================================
  // Per-phase polarizing path
  for (genvar p = 0; p < PDS_NPH; p++) begin : g_pol
    assign v_ok_c[p] = ph.v_mag[p] >= st_ff.thr;
    assign i_ok_c[p] = ph.i_mag[p] >= PDS_IMIN;
    // Live voltage when healthy, otherwise the stored pre-collapse angle
    assign ph.pol_ang[p] = (v_ok_c[p] ? ph.v_ang[p] : st_ff.mem_ang[p]) + st_ff.eca;
  end

  // ==========================================================
  // APB decode
  assign setup_c = psel & ~penable;
  assign wr_c = psel & penable & st_ff.ready & pwrite;

  always_comb begin
    mapped_c = 1'b1;
    rd_c = 32'h0000_0000;
    case (paddr)
      PDS_OFS_CTRL: begin
        rd_c[PDS_CTRL_EN] = st_ff.en;
        rd_c[PDS_CTRL_ACB] = st_ff.acb;
        rd_c[PDS_CTRL_BLK] = st_ff.blk_exp;
        rd_c[PDS_CTRL_SRC +: 2] = st_ff.src;
      end
      PDS_OFS_ECA: begin
        rd_c[15:0] = st_ff.eca;
      end
      PDS_OFS_THR: begin
        rd_c[15:0] = st_ff.thr;
      end
      PDS_OFS_STATUS: begin
        rd_c[PDS_ST_DIR +: PDS_NPH] = st_ff.dir;
        rd_c[PDS_ST_VOK +: PDS_NPH] = st_ff.v_ok;
        rd_c[PDS_ST_MVAL +: PDS_NPH] = st_ff.mem_valid;
        rd_c[PDS_ST_EXP +: PDS_NPH] = st_ff.expired;
      end
      PDS_OFS_MEM_A: begin
        rd_c[15:0] = st_ff.mem_ang[0];
      end
      PDS_OFS_MEM_B: begin
        rd_c[15:0] = st_ff.mem_ang[1];
      end
      PDS_OFS_MEM_C: begin
        rd_c[15:0] = st_ff.mem_ang[2];
      end
      default: begin
        mapped_c = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;

    // Answer is prepared in the setup cycle so pready is high in the first access cycle
    nxt_st.ready = setup_c;
    if (setup_c) begin
      nxt_st.rdata = pwrite ? 32'h0000_0000 : rd_c;
      nxt_st.err = ~mapped_c;
    end else if (psel & penable & st_ff.ready) begin
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.err = 1'b0;
    end

    // Read-only addresses ignore writes without an error
    if (wr_c) begin
      case (paddr)
        PDS_OFS_CTRL: begin
          nxt_st.en = pwdata[PDS_CTRL_EN];
          nxt_st.acb = pwdata[PDS_CTRL_ACB];
          nxt_st.blk_exp = pwdata[PDS_CTRL_BLK];
          nxt_st.src = pwdata[PDS_CTRL_SRC +: 2];
        end
        PDS_OFS_ECA: begin
          nxt_st.eca = pwdata[15:0];
        end
        PDS_OFS_THR: begin
          nxt_st.thr = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // Three identical phase units; none reads another's state
    for (int p = 0; p < PDS_NPH; p++) begin
      nxt_st.v_ok[p] = v_ok_c[p];
      if (v_ok_c[p]) begin
        // Keep tracking so the last healthy sample is what survives the collapse
        nxt_st.mem_ang[p] = ph.v_ang[p];
        nxt_st.tmr[p] = '0;
        nxt_st.mem_valid[p] = 1'b1;
        nxt_st.expired[p] = 1'b0;
      end else if (st_ff.mem_valid[p]) begin
        if (st_ff.tmr[p] >= TMR_LAST) begin
          nxt_st.mem_valid[p] = 1'b0;
          nxt_st.expired[p] = 1'b1;
        end else begin
          nxt_st.tmr[p] = st_ff.tmr[p] + 1'b1;
        end
      end

      // Output 1 inhibits the supervised element downstream
      if (~st_ff.en | ~i_ok_c[p]) begin
        nxt_st.dir[p] = 1'b0;
      end else if (v_ok_c[p] | st_ff.mem_valid[p]) begin
        nxt_st.dir[p] = ~ph.in_window[p];
      end else begin
        nxt_st.dir[p] = st_ff.blk_exp;
      end
    end
  end

  // ==========================================================
  // Registers
  // One cycle of latency here; the ~8 ms settle is set by upstream phasor filtering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.en <= PDS_CTRL_RST[PDS_CTRL_EN];
      st_ff.acb <= PDS_CTRL_RST[PDS_CTRL_ACB];
      st_ff.blk_exp <= PDS_CTRL_RST[PDS_CTRL_BLK];
      st_ff.src <= PDS_CTRL_RST[PDS_CTRL_SRC +: 2];
      st_ff.eca <= PDS_ECA_RST;
      st_ff.thr <= PDS_THR_RST;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.ready <= 1'b0;
      st_ff.err <= 1'b0;
      st_ff.mem_ang <= '0;
      st_ff.tmr <= '0;
      st_ff.mem_valid <= '0;
      // No memory exists yet, so it starts out expired
      st_ff.expired <= '1;
      st_ff.v_ok <= '0;
      st_ff.dir <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign block_out = st_ff.dir;
  assign memory_expired = st_ff.expired;

endmodule

// >>> verif/pds_chk.sv
`timescale 1ns/1ps
module pds_chk import pds_pkg::*; #(
  parameter int unsigned MEM_CYC = PDS_MEM_VALID_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] phase_current_mag,
  input wire logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] line_voltage_mag,
  input wire logic [PDS_NPH-1:0] block_out,
  input wire logic [PDS_NPH-1:0] memory_expired
);
  // ========
  // Shadow settings and the time the phase A line spent under threshold
  typedef struct packed {logic [5:0] ctrl; logic [15:0] thr; logic [31:0] low;} pds_chk_t;
  pds_chk_t st_ff;
  pds_chk_t nxt_st;
  logic wr;
  logic [15:0] v_a;
  logic en;
  logic i_ok;
  logic mem_out;
  assign wr = psel && penable && pready && pwrite;
  assign v_a = line_voltage_mag[st_ff.ctrl[5:4]][1];
  assign en = st_ff.ctrl[0];
  assign i_ok = phase_current_mag[st_ff.ctrl[5:4]][0] >= PDS_IMIN;
  assign mem_out = en && i_ok && v_a < st_ff.thr && memory_expired[0];
  always_comb begin
    nxt_st = st_ff;
    if (wr && paddr == PDS_OFS_CTRL) nxt_st.ctrl = pwdata[5:0];
    if (wr && paddr == PDS_OFS_THR) nxt_st.thr = pwdata[15:0];
    nxt_st.low = (v_a < st_ff.thr) ? st_ff.low + 32'h1 : 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '{ctrl: 6'h00, thr: PDS_THR_RST, low: 32'h0};
    else st_ff <= nxt_st;
  end
  // ========
  // Properties; the timer check trusts THR to stay put during a collapse
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_bad; psel && !penable && (paddr > PDS_OFS_MEM_C || paddr[1:0] != 2'h0); endsequence
  chk_ready_one: assert property (s_setup |=> pready ##1 !pready) else $error("pready width");
  chk_err_map: assert property (s_bad |=> pready && pslverr && prdata == 32'h0) else $error("bad access");
  chk_dis_zero: assert property (!en |=> block_out == 3'h0) else $error("disabled output");
  chk_low_cur: assert property (en && !i_ok |=> !block_out[0]) else $error("low current output");
  chk_v_clear: assert property (v_a >= st_ff.thr |=> !memory_expired[0]) else $error("expiry kept");
  chk_exp_time: assert property ($rose(memory_expired[0]) |-> st_ff.low >= MEM_CYC) else $error("early");
  chk_exp_yes: assert property (mem_out && st_ff.ctrl[2] |=> block_out[0]) else $error("no block");
  chk_exp_no: assert property (mem_out && !st_ff.ctrl[2] |=> !block_out[0]) else $error("blocked");
endmodule
bind pds_top pds_chk #(.MEM_CYC(MEM_CYC)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .phase_current_mag, .line_voltage_mag, .block_out, .memory_expired);

// >>> verif/pds_oc_model.sv
`timescale 1ns/1ps
module pds_oc_model #(
  parameter int DLY = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] block_in,
  input wire logic [2:0] picked_up,
  output logic [2:0] trip
);
  // ========
  // Definite-time element per phase; its delay rides out direction settling
  typedef struct packed {logic [2:0][7:0] cnt;} pds_oc_t;
  pds_oc_t st_ff;
  pds_oc_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    for (int p = 0; p < 3; p++) begin
      nxt_st.cnt[p] = (picked_up[p] && !block_in[p]) ? st_ff.cnt[p] + 8'(st_ff.cnt[p] < 8'(DLY)) : 8'h0;
      trip[p] = st_ff.cnt[p] == 8'(DLY);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_ff <= '0;
    else st_ff <= nxt_st;
  end
endmodule

// >>> verif/tb_phase_direction_supervisor.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[ERR] %0t %h %h", $time, a, b); \
  end \
end
module tb_phase_direction_supervisor;
  import pds_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PDS_NSRC-1:0][PDS_NPH-1:0][15:0] cm = '0, ca = '0, vm = '0, va = '0;
  logic [2:0] blk;
  logic [2:0] expd;
  logic [2:0] trip;
  logic [31:0] rd;
  logic err;
  logic [15:0] pol_exp;
  logic [15:0] dt [6] = '{16'h0000, 16'h4000, 16'h4001, 16'h8000, 16'hbfff, 16'hc000};
  int num_errors = 0;
  int samples_checked = 0;
  // ========
  // Memory time shortened to 20 cycles
  pds_top #(.MEM_CYC(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .phase_current_mag(cm), .phase_current_ang(ca), .line_voltage_mag(vm), .line_voltage_ang(va),
    .block_out(blk), .memory_expired(expd));
  pds_oc_model #(.DLY(4)) i_oc (.pclk, .presetn, .block_in(blk), .picked_up(3'b111), .trip);
  initial forever #50 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic dir(input logic [15:0] i, input logic [15:0] pol);
    logic [15:0] d;
    d = i - pol;
    return d > 16'h4000 && d < 16'hc000;
  endfunction
  task automatic close_out();
    $display("num_errors %0d samples_checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PDS_OFS_THR, 32'h0);
    `CHK(rd, 32'h0000_0b33)
    apb(1'b0, 12'h01c, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h002, 32'h1);
    `CHK(err, 1'b1)
    // Unselected sources see every line voltage at 180 degrees, so a wrong pick shows
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 3; p++) begin
        cm[s][p] <= 16'h1000;
        vm[s][p] <= 16'h1000;
        va[s][p] <= (s == 2) ? 16'(p * 16'h2000) : 16'h8000;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int r = 0; r < 2; r++) begin
        for (int e = 0; e < 2; e++) begin
          apb(1'b1, PDS_OFS_CTRL, 32'h21 | 32'(r << 1));
          apb(1'b1, PDS_OFS_ECA, 32'(e * 16'h3000));
          ca <= {12{dt[k]}};
          settle();
          for (int p = 0; p < 3; p++) begin
            pol_exp = 16'(((p + 1) % 3) * 16'h2000 + r * 16'h8000 + e * 16'h3000);
            `CHK(blk[p], dir(dt[k], pol_exp))
          end
        end
      end
    end
    apb(1'b1, PDS_OFS_CTRL, 32'h21);
    apb(1'b1, PDS_OFS_ECA, 32'h0);
    ca <= {12{16'h8000}};
    cm[2][0] <= 16'd204;
    cm[2][2] <= 16'd205;
    settle();
    `CHK(blk, 3'b100)
    apb(1'b1, PDS_OFS_CTRL, 32'h20);
    settle();
    `CHK(blk, 3'b000)
    // Collapse the phase A line after a forward decision, swinging its angle in the same step
    apb(1'b1, PDS_OFS_CTRL, 32'h25);
    cm[2][0] <= 16'h1000;
    ca <= {12{16'h2000}};
    settle();
    `CHK(blk[0], 1'b0)
    vm[2][1] <= 16'd2866;
    va[2][1] <= 16'ha000;
    settle();
    `CHK(blk[0], 1'b0)
    // Expiry lands exactly MEM_CYC cycles after the collapse
    repeat (18) @(posedge pclk);
    `CHK(expd[0], 1'b0)
    @(posedge pclk);
    `CHK(expd[0], 1'b1)
    repeat (2) @(posedge pclk);
    `CHK(blk[0], 1'b1)
    `CHK(trip[0], 1'b0)
    apb(1'b1, PDS_OFS_CTRL, 32'h21);
    // The new option steers the decision one edge after the write
    @(posedge pclk);
    `CHK(blk[0], 1'b0)
    `CHK(trip[0], 1'b0)
    repeat (6) @(posedge pclk);
    `CHK(trip[0], 1'b1)
    vm[2][1] <= 16'd2867;
    settle();
    `CHK(expd[0], 1'b0)
    `CHK(blk[0], 1'b1)
    close_out();
  end
endmodule
